/* File: hdl/serial_bit_rate_and_card_format.sv */
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Card mode bits 7..4 read one, ignore writes
// - Card mode bit 1 reads one, ignores writes
// - Bit 3 selects LSB or MSB first
// - Order select applies only to eight-bit characters
// - Bit 2 inverts transmit and receive data
// - Inversion leaves parity bit level alone
// - Bit 0 selects smart card mode
// - Divisor is eight bits, resets all ones, always accessible
// - Each channel has its own rate generator
// - Divisor 0..255 divides by N plus one
// - Async 64, sync 8 times 2^(2n-1)(N+1)
// - Card mode S times 2^(2n+1)(N+1)
// - Codes map n 0..3, S 32/64/372/256
module serial_bit_rate_and_card_format (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  // Register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Serial line
  input  wire logic       i_rxd,
  output logic            o_txd,
  output logic            o_txd_oe_n,
  // Mode indication
  output logic            o_card_mode
);

  typedef struct packed {
    logic                  msb_first;
    logic                  invert;
    logic                  card_mode;
    logic [7:0]            divisor;
    logic [7:0]            fmt;
    logic [7:0]            tx_hold;
    logic                  tx_pend;
    ser_pkg::tx_state_t    tx_st;
    logic [2:0]            tx_bit;
    logic [7:0]            tx_shift;
    logic                  tx_par;
    logic                  txd;
    logic                  txd_oe_n;
    logic                  tx_go;
    ser_pkg::rx_state_t    rx_st;
    logic [2:0]            rx_bit;
    logic [7:0]            rx_raw;
    logic                  rx_par;
    logic                  rx_go;
    logic [7:0]            rx_hold;
    logic                  rx_full;
    logic                  par_err;
    logic [7:0]            rdata;
  } top_state_t;

  top_state_t          st_r;
  top_state_t          st_nxt;
  ser_pkg::reg_req_t   req;
  ser_pkg::rate_cfg_t  rate_cfg;
  ser_pkg::fmt_ctl_t   fmt_ctl;
  logic                tx_bit_p;
  logic                rx_mid_p;
  logic [7:0]          tx_line;
  logic                tx_parity;
  logic [7:0]          rx_store;
  logic                rx_parity;
  logic [2:0]          last_bit;
  logic                par_en;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  always_comb begin
    if (st_r.card_mode) begin
      rate_cfg.mode = ser_pkg::MODE_CARD;
    end else if (st_r.fmt[ser_pkg::FMT_SYNC_BIT]) begin
      rate_cfg.mode = ser_pkg::MODE_SYNC;
    end else begin
      rate_cfg.mode = ser_pkg::MODE_ASYNC;
    end
    rate_cfg.prescale = st_r.fmt[ser_pkg::FMT_PRESCALE_LSB +: 2];
    rate_cfg.card_clk = st_r.fmt[ser_pkg::FMT_CARDCLK_LSB +: 2];
    rate_cfg.divisor  = st_r.divisor;
  end

  assign fmt_ctl.msb_first = st_r.msb_first;
  assign fmt_ctl.invert    = st_r.invert;
  assign fmt_ctl.chr7      = st_r.fmt[ser_pkg::FMT_CHR7_BIT];
  assign fmt_ctl.par_odd   = st_r.fmt[ser_pkg::FMT_PAR_ODD_BIT];
  assign par_en            = st_r.fmt[ser_pkg::FMT_PAR_EN_BIT];
  assign last_bit          = fmt_ctl.chr7 ? 3'h6 : 3'h7;

  // Separate generators for the two directions: the receiver realigns its
  // own phase on every start edge without disturbing a frame in flight.
  // The transmit generator restarts in the cycle that launches the start bit,
  // otherwise the start bit would be stretched by the restart latency.
  ser_rate_gen u_tx_gen (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_cfg     (rate_cfg),
    .i_restart (st_nxt.tx_go),
    .o_tick    (),
    .o_bit     (tx_bit_p),
    .o_mid     ()
  );

  ser_rate_gen u_rx_gen (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_cfg     (rate_cfg),
    .i_restart (st_r.rx_go),
    .o_tick    (),
    .o_bit     (),
    .o_mid     (rx_mid_p)
  );

  ser_data_format u_fmt (
    .i_ctl       (fmt_ctl),
    .i_tx_data   (st_r.tx_hold),
    .o_tx_line   (tx_line),
    .o_tx_parity (tx_parity),
    .i_rx_raw    (st_r.rx_raw),
    .o_rx_store  (rx_store),
    .o_rx_parity (rx_parity)
  );

  always_comb begin
    st_nxt       = st_r;
    st_nxt.tx_go = 1'b0;
    st_nxt.rx_go = 1'b0;

    // Register writes.
    if (req.wr) begin
      unique case (req.addr)
        ser_pkg::OFS_CARD_MODE: begin
          st_nxt.msb_first = req.wdata[ser_pkg::CMC_ORDER_BIT];
          st_nxt.invert    = req.wdata[ser_pkg::CMC_INVERT_BIT];
          st_nxt.card_mode = req.wdata[ser_pkg::CMC_MODE_SEL_BIT];
        end
        ser_pkg::OFS_RATE_DIVISOR:  st_nxt.divisor = req.wdata;
        ser_pkg::OFS_SERIAL_FORMAT: st_nxt.fmt     = req.wdata;
        ser_pkg::OFS_TX_HOLDING: begin
          st_nxt.tx_hold = req.wdata;
          st_nxt.tx_pend = 1'b1;
        end
        default: ;
      endcase
    end

    // Register reads; data stands one cycle after the strobe only.
    st_nxt.rdata = ser_pkg::ZERO_BYTE;
    if (req.rd) begin
      unique case (req.addr)
        ser_pkg::OFS_CARD_MODE: begin
          st_nxt.rdata = ser_pkg::CMC_FIXED_ONES;
          st_nxt.rdata[ser_pkg::CMC_ORDER_BIT]    = st_r.msb_first;
          st_nxt.rdata[ser_pkg::CMC_INVERT_BIT]   = st_r.invert;
          st_nxt.rdata[ser_pkg::CMC_MODE_SEL_BIT] = st_r.card_mode;
        end
        ser_pkg::OFS_RATE_DIVISOR:  st_nxt.rdata = st_r.divisor;
        ser_pkg::OFS_SERIAL_FORMAT: st_nxt.rdata = st_r.fmt;
        ser_pkg::OFS_TX_HOLDING:    st_nxt.rdata = st_r.tx_hold;
        ser_pkg::OFS_RX_HOLDING: begin
          st_nxt.rdata   = st_r.rx_hold;
          st_nxt.rx_full = 1'b0;
        end
        ser_pkg::OFS_STATUS: begin
          st_nxt.rdata[ser_pkg::STS_TX_BUSY_BIT] = st_r.tx_pend || (st_r.tx_st != ser_pkg::TX_IDLE);
          st_nxt.rdata[ser_pkg::STS_RX_FULL_BIT] = st_r.rx_full;
          st_nxt.rdata[ser_pkg::STS_PAR_ERR_BIT] = st_r.par_err;
          st_nxt.par_err = 1'b0;
        end
        default: st_nxt.rdata = ser_pkg::ZERO_BYTE;
      endcase
    end

    // Transmitter.
    unique case (st_r.tx_st)
      ser_pkg::TX_IDLE: begin
        st_nxt.txd = 1'b1;
        if (st_r.tx_pend && !req.wr) begin
          st_nxt.tx_go    = 1'b1;
          st_nxt.tx_pend  = 1'b0;
          st_nxt.tx_shift = tx_line;
          st_nxt.tx_par   = tx_parity;
          st_nxt.tx_bit   = 3'h0;
          st_nxt.txd      = 1'b0;
          st_nxt.tx_st    = ser_pkg::TX_START;
        end
      end
      ser_pkg::TX_START: begin
        if (tx_bit_p) begin
          st_nxt.txd   = st_r.tx_shift[0];
          st_nxt.tx_st = ser_pkg::TX_DATA;
        end
      end
      ser_pkg::TX_DATA: begin
        if (tx_bit_p) begin
          if (st_r.tx_bit == last_bit) begin
            st_nxt.txd   = par_en ? st_r.tx_par : 1'b1;
            st_nxt.tx_st = par_en ? ser_pkg::TX_PARITY : ser_pkg::TX_STOP;
          end else begin
            st_nxt.tx_bit = st_r.tx_bit + 3'h1;
            st_nxt.txd    = st_r.tx_shift[st_r.tx_bit + 3'h1];
          end
        end
      end
      ser_pkg::TX_PARITY: begin
        if (tx_bit_p) begin
          st_nxt.txd   = 1'b1;
          st_nxt.tx_st = ser_pkg::TX_STOP;
        end
      end
      ser_pkg::TX_STOP: begin
        if (tx_bit_p) begin
          st_nxt.tx_st = ser_pkg::TX_IDLE;
        end
      end
      default: st_nxt.tx_st = ser_pkg::TX_IDLE;
    endcase
    // In card mode the line is shared, so only a low level is driven.
    st_nxt.txd_oe_n = st_nxt.card_mode && st_nxt.txd;

    // Receiver.
    unique case (st_r.rx_st)
      ser_pkg::RX_IDLE: begin
        if (!i_rxd) begin
          st_nxt.rx_go  = 1'b1;
          st_nxt.rx_bit = 3'h0;
          st_nxt.rx_st  = ser_pkg::RX_START;
        end
      end
      ser_pkg::RX_START: begin
        if (rx_mid_p) begin
          st_nxt.rx_st = i_rxd ? ser_pkg::RX_IDLE : ser_pkg::RX_DATA;
        end
      end
      ser_pkg::RX_DATA: begin
        if (rx_mid_p) begin
          st_nxt.rx_raw[st_r.rx_bit] = i_rxd;
          if (st_r.rx_bit == last_bit) begin
            if (fmt_ctl.chr7) begin
              st_nxt.rx_raw[7] = 1'b0;
            end
            st_nxt.rx_st = par_en ? ser_pkg::RX_PARITY : ser_pkg::RX_STOP;
          end else begin
            st_nxt.rx_bit = st_r.rx_bit + 3'h1;
          end
        end
      end
      ser_pkg::RX_PARITY: begin
        if (rx_mid_p) begin
          st_nxt.rx_par = i_rxd;
          st_nxt.rx_st  = ser_pkg::RX_STOP;
        end
      end
      ser_pkg::RX_STOP: begin
        if (rx_mid_p) begin
          // Setting the flags after the read clear gives the event priority.
          st_nxt.rx_hold = rx_store;
          st_nxt.rx_full = 1'b1;
          if (par_en && (st_r.rx_par != rx_parity)) begin
            st_nxt.par_err = 1'b1;
          end
          st_nxt.rx_st = ser_pkg::RX_IDLE;
        end
      end
      default: st_nxt.rx_st = ser_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st_r          <= '0;
      st_r.divisor  <= ser_pkg::DIVISOR_RESET;
      st_r.fmt      <= ser_pkg::FMT_RESET;
      st_r.txd      <= 1'b1;
      st_r.txd_oe_n <= 1'b0;
      st_r.tx_st    <= ser_pkg::TX_IDLE;
      st_r.rx_st    <= ser_pkg::RX_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata     = st_r.rdata;
  assign o_txd       = st_r.txd;
  assign o_txd_oe_n  = st_r.txd_oe_n;
  assign o_card_mode = st_r.card_mode;

  // Checks.
  sequence s_cmc_read;
    i_rd && i_addr == ser_pkg::OFS_CARD_MODE;
  endsequence

  a_cmc_high_ones: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    s_cmc_read |=> o_rdata[7:4] == 4'hf)
    else $error("Card mode upper bits did not read as ones.");

  a_cmc_bit1_one: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    s_cmc_read |=> o_rdata[1] == 1'b1)
    else $error("Card mode bit 1 did not read as one.");

  a_divisor_reset: assert property (@(posedge i_clk)
    $rose(i_reset_n) |-> st_r.divisor == ser_pkg::DIVISOR_RESET)
    else $error("Divisor not all ones after reset.");

  sequence s_div_write;
    i_wr && i_addr == ser_pkg::OFS_RATE_DIVISOR;
  endsequence

  a_divisor_rw: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (s_div_write ##1 (i_rd && i_addr == ser_pkg::OFS_RATE_DIVISOR && !i_wr))
    |=> o_rdata == $past(i_wdata, 2))
    else $error("Divisor read-back differs from value written.");

  a_card_rate_mode: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    st_r.card_mode |-> rate_cfg.mode == ser_pkg::MODE_CARD)
    else $error("Card mode select did not steer the rate generator.");

  a_tx_start_low: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    st_r.tx_go |-> !o_txd && st_r.tx_st == ser_pkg::TX_START
      && st_r.tx_shift == tx_line)
    else $error("Frame start did not load formatted data or drive start bit.");

  a_parity_level: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_r.tx_st == ser_pkg::TX_PARITY && !st_r.tx_pend)
      |-> o_txd == (^(st_r.tx_hold & (fmt_ctl.chr7 ? 8'h7f : 8'hff)) ^ fmt_ctl.par_odd))
    else $error("Parity level depends on data inversion.");

  a_seven_lsb_first: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_r.tx_go && fmt_ctl.chr7 && !fmt_ctl.invert) |-> st_r.tx_shift == (st_r.tx_hold & 8'h7f))
    else $error("Seven-bit data not sent LSB first.");

endmodule
`default_nettype wire

/* File: hdl/ser_pkg.sv */
package ser_pkg;

  // Register map, byte offsets on the 8-bit register port.
  localparam logic [7:0] OFS_CARD_MODE     = 8'h00;
  localparam logic [7:0] OFS_RATE_DIVISOR  = 8'h01;
  localparam logic [7:0] OFS_SERIAL_FORMAT = 8'h02;
  localparam logic [7:0] OFS_TX_HOLDING    = 8'h03;
  localparam logic [7:0] OFS_RX_HOLDING    = 8'h04;
  localparam logic [7:0] OFS_STATUS        = 8'h05;

  // Card mode control layout.
  localparam int         CMC_MODE_SEL_BIT = 0;
  localparam int         CMC_INVERT_BIT   = 2;
  localparam int         CMC_ORDER_BIT    = 3;
  localparam logic [7:0] CMC_FIXED_ONES   = 8'hf2;
  localparam logic [7:0] CMC_RESET        = 8'hf2;

  // Serial format register layout.
  localparam int         FMT_PRESCALE_LSB = 0;
  localparam int         FMT_CARDCLK_LSB  = 2;
  localparam int         FMT_PAR_ODD_BIT  = 4;
  localparam int         FMT_PAR_EN_BIT   = 5;
  localparam int         FMT_CHR7_BIT     = 6;
  localparam int         FMT_SYNC_BIT     = 7;
  localparam logic [7:0] FMT_RESET        = 8'h00;

  // Status register layout.
  localparam int         STS_TX_BUSY_BIT  = 0;
  localparam int         STS_RX_FULL_BIT  = 1;
  localparam int         STS_PAR_ERR_BIT  = 2;

  localparam logic [7:0] DIVISOR_RESET    = 8'hff;
  localparam logic [7:0] ZERO_BYTE        = 8'h00;

  // Basic clock ticks per bit for each mode; card mode uses a selected count.
  localparam logic [8:0] ASYNC_TICKS      = 9'h010;
  localparam logic [8:0] SYNC_TICKS       = 9'h002;
  localparam logic [8:0] CARD_TICKS_0     = 9'h020;
  localparam logic [8:0] CARD_TICKS_1     = 9'h040;
  localparam logic [8:0] CARD_TICKS_2     = 9'h174;
  localparam logic [8:0] CARD_TICKS_3     = 9'h100;

  typedef enum logic [1:0] {
    MODE_ASYNC = 2'b00,
    MODE_SYNC  = 2'b01,
    MODE_CARD  = 2'b10
  } rate_mode_t;

  typedef enum logic [2:0] {
    TX_IDLE   = 3'b000,
    TX_START  = 3'b001,
    TX_DATA   = 3'b010,
    TX_PARITY = 3'b011,
    TX_STOP   = 3'b100
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE   = 3'b000,
    RX_START  = 3'b001,
    RX_DATA   = 3'b010,
    RX_PARITY = 3'b011,
    RX_STOP   = 3'b100
  } rx_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic msb_first;
    logic invert;
    logic chr7;
    logic par_odd;
  } fmt_ctl_t;

  typedef struct packed {
    rate_mode_t mode;
    logic [1:0] prescale;
    logic [1:0] card_clk;
    logic [7:0] divisor;
  } rate_cfg_t;

  // Prescaler terminal count: 2 * 4^n cycles per step.
  function automatic logic [6:0] prescale_last(input logic [1:0] n);
    prescale_last = 7'(({5'h00, 2'b10} << {n, 1'b0}) - 7'h01);
  endfunction

  function automatic logic [8:0] ticks_per_bit(input rate_mode_t m, input logic [1:0] s);
    unique case (m)
      MODE_ASYNC: ticks_per_bit = ASYNC_TICKS;
      MODE_SYNC:  ticks_per_bit = SYNC_TICKS;
      default: begin
        unique case (s)
          2'b00:   ticks_per_bit = CARD_TICKS_0;
          2'b01:   ticks_per_bit = CARD_TICKS_1;
          2'b10:   ticks_per_bit = CARD_TICKS_2;
          default: ticks_per_bit = CARD_TICKS_3;
        endcase
      end
    endcase
  endfunction

endpackage

/* File: hdl/ser_rate_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module ser_rate_gen (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  // Control
  input  wire ser_pkg::rate_cfg_t i_cfg,
  input  wire logic              i_restart,
  // Timing pulses
  output logic                   o_tick,
  output logic                   o_bit,
  output logic                   o_mid
);

  typedef struct packed {
    logic [6:0] pre_cnt;
    logic [7:0] div_cnt;
    logic [8:0] tick_cnt;
    logic       tick;
    logic       bitp;
    logic       mid;
  } gen_state_t;

  gen_state_t st_r;
  gen_state_t st_nxt;
  logic [8:0] tpb;

  assign tpb = ser_pkg::ticks_per_bit(i_cfg.mode, i_cfg.card_clk);

  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    st_nxt.bitp = 1'b0;
    st_nxt.mid  = 1'b0;
    if (i_restart) begin
      // The restart cycle counts as the first prescaler step, so a line change
      // made on the registered bit pulse still gets exactly one bit time.
      st_nxt.pre_cnt  = 7'h01;
      st_nxt.div_cnt  = i_cfg.divisor;
      st_nxt.tick_cnt = 9'h000;
    end else if (st_r.pre_cnt == ser_pkg::prescale_last(i_cfg.prescale)) begin
      st_nxt.pre_cnt = 7'h00;
      if (st_r.div_cnt == 8'h00) begin
        // Reloading only on expiry or restart lets software retune without a glitch.
        st_nxt.div_cnt = i_cfg.divisor;
        st_nxt.tick    = 1'b1;
        if (st_r.tick_cnt >= tpb - 9'h001) begin
          st_nxt.tick_cnt = 9'h000;
          st_nxt.bitp     = 1'b1;
        end else begin
          st_nxt.tick_cnt = st_r.tick_cnt + 9'h001;
        end
        if (st_r.tick_cnt == (tpb >> 1) - 9'h001) begin
          st_nxt.mid = 1'b1;
        end
      end else begin
        st_nxt.div_cnt = st_r.div_cnt - 8'h01;
      end
    end else begin
      st_nxt.pre_cnt = st_r.pre_cnt + 7'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_tick = st_r.tick;
  assign o_bit  = st_r.bitp;
  assign o_mid  = st_r.mid;

  // Helper: cycles since the last tick, and whether settings held still.
  logic [15:0]        gap_cnt;
  logic               cfg_steady;
  ser_pkg::rate_cfg_t cfg_q;
  logic [15:0]        want_gap;

  assign want_gap = 16'(({14'h0000, 2'b10} << {i_cfg.prescale, 1'b0})
                    * ({8'h00, i_cfg.divisor} + 16'h0001));

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      gap_cnt    <= 16'h0000;
      cfg_steady <= 1'b0;
      cfg_q      <= '0;
    end else begin
      cfg_q <= i_cfg;
      if (st_r.tick || i_restart) begin
        gap_cnt    <= 16'h0001;
        cfg_steady <= !i_restart && (cfg_q == i_cfg);
      end else begin
        gap_cnt    <= gap_cnt + 16'h0001;
        cfg_steady <= cfg_steady && (cfg_q == i_cfg);
      end
    end
  end

  a_tick_period: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_r.tick && cfg_steady && cfg_q == i_cfg) |-> gap_cnt == want_gap)
    else $error("Basic clock tick period does not match divisor and prescaler.");

  a_bit_on_tick: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    st_r.bitp |-> st_r.tick && st_r.tick_cnt == 9'h000)
    else $error("Bit pulse not aligned with a tick wrap.");

  a_mid_before_bit: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_r.mid && !i_restart) |-> !st_r.bitp)
    else $error("Mid-bit pulse coincides with bit boundary.");

endmodule
`default_nettype wire

/* File: hdl/ser_data_format.sv */
`timescale 1ns/1ps
`default_nettype none
module ser_data_format (
  // Format control
  input  wire ser_pkg::fmt_ctl_t i_ctl,
  // Transmit side
  input  wire logic [7:0]        i_tx_data,
  output logic      [7:0]        o_tx_line,
  output logic                   o_tx_parity,
  // Receive side
  input  wire logic [7:0]        i_rx_raw,
  output logic      [7:0]        o_rx_store,
  output logic                   o_rx_parity
);

  function automatic logic [7:0] reverse8(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      reverse8[i] = d[7 - i];
    end
  endfunction

  logic [7:0] mask;
  logic [7:0] tx_ord;
  logic [7:0] rx_inv;

  assign mask = i_ctl.chr7 ? 8'h7f : 8'hff;

  // Seven-bit characters ignore the order select and always go LSB first.
  assign tx_ord    = (i_ctl.msb_first && !i_ctl.chr7) ? reverse8(i_tx_data) : i_tx_data;
  assign o_tx_line = (i_ctl.invert ? ~tx_ord : tx_ord) & mask;

  assign rx_inv     = (i_ctl.invert ? ~i_rx_raw : i_rx_raw) & mask;
  assign o_rx_store = (i_ctl.msb_first && !i_ctl.chr7) ? reverse8(rx_inv) : rx_inv;

  // Parity covers the holding contents, so inversion never touches it.
  assign o_tx_parity = ^(i_tx_data & mask) ^ i_ctl.par_odd;
  assign o_rx_parity = ^(o_rx_store & mask) ^ i_ctl.par_odd;

endmodule
`default_nettype wire

/* File: sim/line_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module line_partner (
  // Clock
  input  wire logic i_clk,
  // Serial line
  input  wire logic i_txd,
  output logic      o_rxd
);
  initial o_rxd = 1'b1;

  // Sampling sits mid-bit so it never meets a line edge.
  task automatic get_frame(input int bt, input int nb, output logic [9:0] bits);
    int i;
    bits = '1;
    i = 0;
    while (i_txd !== 1'b0 && i < 20000) begin
      @(posedge i_clk);
      i++;
    end
    // An all-zero frame tells the caller that no start bit came.
    if (i == 20000) begin
      bits = '0;
      return;
    end
    repeat (bt / 2) @(posedge i_clk);
    for (i = 0; i < nb; i++) begin
      repeat (bt) @(posedge i_clk);
      bits[i] = i_txd;
    end
    repeat (bt) @(posedge i_clk);
  endtask

  task automatic send(input int bt, input logic [7:0] v);
    logic [9:0] frame;
    int         i;
    frame = {1'b1, v, 1'b0};
    for (i = 0; i < 10; i++) begin
      @(posedge i_clk);
      o_rxd <= frame[i];
      repeat (bt - 1) @(posedge i_clk);
    end
  endtask
endmodule
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       i_clk;
  logic       i_reset_n;
  logic [7:0] i_addr;
  logic [7:0] i_wdata;
  logic       i_wr;
  logic       i_rd;
  logic [7:0] o_rdata;
  wire logic  rx_line;
  logic       o_txd;
  logic       o_txd_oe_n;
  logic       o_card_mode;
  wire logic  line;
  int         bad_count;
  int         total_checks;
  int         k;

  // Released pin is pulled high, as in card mode.
  assign line = (o_txd_oe_n === 1'b0) ? o_txd : 1'b1;

  serial_bit_rate_and_card_format serial_bit_rate_and_card_format_i (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(rx_line), .o_txd(o_txd),
    .o_txd_oe_n(o_txd_oe_n), .o_card_mode(o_card_mode));
  line_partner line_partner_i (.i_clk(i_clk), .i_txd(line), .o_rxd(rx_line));

  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1;
    chk(nm, {4'h0, o_rdata}, {4'h0, exp});
  endtask

  task automatic wr_rd(input string nm, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
    i_rd    <= 1'b1;
    @(posedge i_clk);
    i_rd    <= 1'b0;
    #1;
    chk(nm, {4'h0, o_rdata}, {4'h0, d});
  endtask

  task automatic tx(input string nm, input logic [7:0] d, input int nb, input logic [9:0] exp);
    logic [9:0] got;
    wr(ser_pkg::OFS_TX_HOLDING, d);
    line_partner_i.get_frame(32, nb, got);
    chk(nm, {2'b00, got}, {2'b00, exp});
    if (got === 10'h000) begin
      end_sim();
    end
    repeat (40) @(posedge i_clk);
  endtask

  // Start bit of an all-ones byte is the only low stretch, so it gives the bit time.
  task automatic meas(input string nm, input logic [7:0] fmt, input int bt);
    int i;
    int len;
    len = 0;
    wr(ser_pkg::OFS_SERIAL_FORMAT, fmt);
    wr(ser_pkg::OFS_TX_HOLDING, 8'hff);
    for (i = 0; i < 200 && line !== 1'b0; i++) @(negedge i_clk);
    while (line === 1'b0 && len < 3000) begin
      @(negedge i_clk);
      len++;
    end
    chk(nm, 12'(len), 12'(bt));
    if (len == 0 || len == 3000) begin
      end_sim();
    end
    repeat (10 * bt) @(posedge i_clk);
  endtask

  task automatic t_regs();
    rd("cmc_reset", ser_pkg::OFS_CARD_MODE, 8'hf2);
    rd("div_reset", ser_pkg::OFS_RATE_DIVISOR, 8'hff);
    wr(ser_pkg::OFS_CARD_MODE, 8'h00);
    rd("cmc_zero", ser_pkg::OFS_CARD_MODE, 8'hf2);
    wr(ser_pkg::OFS_CARD_MODE, 8'h0d);
    rd("cmc_set", ser_pkg::OFS_CARD_MODE, 8'hff);
    chk("card_on", {11'h000, o_card_mode}, 12'h001);
    wr(ser_pkg::OFS_CARD_MODE, 8'hf2);
    #1;
    chk("card_off", {11'h000, o_card_mode}, 12'h000);
    wr_rd("div_rw", ser_pkg::OFS_RATE_DIVISOR, 8'h5a);
    rd("unmapped", 8'h3f, 8'h00);
    wr(ser_pkg::OFS_RATE_DIVISOR, 8'h00);
    rd("div_zero", ser_pkg::OFS_RATE_DIVISOR, 8'h00);
  endtask

  task automatic t_order();
    tx("lsb_first", 8'h35, 8, {2'b11, 8'h35});
    wr(ser_pkg::OFS_CARD_MODE, 8'hfa);
    tx("msb_first", 8'h35, 8, {2'b11, 8'hac});
    wr(ser_pkg::OFS_SERIAL_FORMAT, 8'h40);
    tx("chr7_lsb", 8'h35, 7, {3'b111, 7'h35});
  endtask

  task automatic t_invert();
    wr(ser_pkg::OFS_CARD_MODE, 8'hf6);
    wr(ser_pkg::OFS_SERIAL_FORMAT, 8'h00);
    tx("inv_data", 8'h35, 8, {2'b11, 8'hca});
    wr(ser_pkg::OFS_SERIAL_FORMAT, 8'h20);
    tx("inv_par_even", 8'h35, 9, {1'b1, 1'b0, 8'hca});
    wr(ser_pkg::OFS_SERIAL_FORMAT, 8'h30);
    tx("inv_par_odd", 8'h35, 9, {1'b1, 1'b1, 8'hca});
  endtask

  task automatic t_receive();
    wr(ser_pkg::OFS_SERIAL_FORMAT, 8'h00);
    line_partner_i.send(32, 8'h35);
    repeat (4) @(posedge i_clk);
    rd("rx_inv", ser_pkg::OFS_RX_HOLDING, 8'hca);
    wr(ser_pkg::OFS_CARD_MODE, 8'hfe);
    line_partner_i.send(32, 8'h35);
    repeat (4) @(posedge i_clk);
    rd("rx_inv_msb", ser_pkg::OFS_RX_HOLDING, 8'h53);
    wr(ser_pkg::OFS_CARD_MODE, 8'hf2);
  endtask

  task automatic t_rate();
    for (k = 0; k < 4; k++) begin
      meas("async_n", 8'(k), 32 << (2 * k));
    end
    wr(ser_pkg::OFS_RATE_DIVISOR, 8'h02);
    meas("async_div", 8'h01, 384);
    wr(ser_pkg::OFS_RATE_DIVISOR, 8'h00);
    meas("sync_rate", 8'h80, 4);
    wr(ser_pkg::OFS_CARD_MODE, 8'hf3);
    meas("card_s32", 8'h00, 64);
    meas("card_s64", 8'h04, 128);
    meas("card_s372", 8'h08, 744);
    meas("card_s256", 8'h0c, 512);
    chk("card_release", {11'h000, o_txd_oe_n}, 12'h001);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  initial begin
    bad_count = 0;
    total_checks = 0;
    i_reset_n = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_regs();
    t_order();
    t_invert();
    t_receive();
    t_rate();
    end_sim();
  end
endmodule
`default_nettype wire
